// ===== design/rtl_pkg.sv
// Purpose: Constants for the remote temperature limit register block
// Assumes: 8-bit register port, 125 MHz clock
// Notes: Offsets are the register addresses on the local port
package rtl_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_READ_HI = 8'h01;
   localparam logic [7:0] ADDR_HILIM_HI = 8'h07;
   localparam logic [7:0] ADDR_LOLIM_HI = 8'h08;
   localparam logic [7:0] ADDR_READ_LO = 8'h10;
   localparam logic [7:0] ADDR_OFS_HI = 8'h11;
   localparam logic [7:0] ADDR_OFS_LO = 8'h12;
   localparam logic [7:0] ADDR_HILIM_LO = 8'h13;
   localparam logic [7:0] ADDR_LOLIM_LO = 8'h14;
   localparam logic [7:0] ADDR_CRIT = 8'h19;
   localparam logic [7:0] ADDR_HYST = 8'h21;
   localparam logic [7:0] ADDR_FILT = 8'hbf;
   localparam logic [7:0] ADDR_STAT = 8'hf0;
   localparam logic [7:0] ADDR_MASK = 8'hf1;
   // Reset values
   localparam logic [7:0] RST_HILIM_HI = 8'h46;
   localparam logic [7:0] RST_CRIT = 8'h55;
   localparam logic [7:0] RST_HYST = 8'h0a;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // Fraction field: bits 7:5 of the low byte
   localparam logic [7:0] FRAC_MASK = 8'he0;
   localparam int FRAC_W = 3;
   // Filter field and mode bit
   localparam int FILT_LSB = 1;
   localparam int MODE_BIT = 0;
   localparam logic [7:0] FILT_WMASK = 8'h07;
   // Status bit positions
   localparam int ST_HIGH = 0;
   localparam int ST_LOW = 1;
   localparam int ST_CRIT = 2;
   localparam int ST_W = 3;
   // Filter shift amounts for the running average
   localparam int SHIFT_MIN = 1;
   localparam int SHIFT_MAX = 3;
   typedef enum logic [1:0]
   {
      RTL_FILT_OFF = 2'b00,
      RTL_FILT_MIN1 = 2'b01,
      RTL_FILT_MIN2 = 2'b10,
      RTL_FILT_MAX = 2'b11
   } rtl_filt_type;
endpackage

// ===== design/rtl_reg8.sv
// Purpose: One 8-bit software register with reset value and write mask
// Assumes: Synchronous active-high reset
// Notes: Bits outside the mask read as zero
`timescale 1ns/1ps
`default_nettype none
module rtl_reg8 #(
   parameter logic [7:0] RST = 8'h00,
   parameter logic [7:0] WMASK = 8'hff
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Write side
   input wire logic wr,
   input wire logic [7:0] wdata,
   // Value
   output logic [7:0] q
);
   logic [7:0] q_reg;

   // Store masked data
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         q_reg <= RST & WMASK;
      else if (wr)
         q_reg <= wdata & WMASK;
   end

   assign q = q_reg;
endmodule
`default_nettype wire

// ===== design/rtl_filter.sv
// Purpose: Selectable running-average filter on an 11-bit reading
// Assumes: One new sample per sample_valid pulse
// Notes: Output register is updated one cycle after each sample
`timescale 1ns/1ps
`default_nettype none
module rtl_filter
   import rtl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control
   input wire logic [1:0] mode,
   // Sample in
   input wire logic sample_valid,
   input wire logic signed [10:0] sample,
   // Filtered out
   output logic out_valid,
   output logic signed [10:0] out
);
   import rtl_pkg::*;
   logic signed [10:0] out_reg;
   logic out_valid_reg;
   logic signed [13:0] diff;
   logic signed [13:0] step;

   // Step toward the sample by a fraction set by the filter level
   always_comb
   begin
      diff = 14'(sample) - 14'(out_reg);
      unique case (rtl_filt_type'(mode))
         RTL_FILT_OFF: step = diff;
         RTL_FILT_MIN1,
         RTL_FILT_MIN2: step = diff >>> SHIFT_MIN;
         RTL_FILT_MAX: step = diff >>> SHIFT_MAX;
      endcase
   end

   // Average holds its state; filter off just tracks the input
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         out_reg <= '0;
         out_valid_reg <= 1'b0;
      end
      else
      begin
         out_valid_reg <= sample_valid;
         if (sample_valid)
            out_reg <= 11'(14'(out_reg) + step);
      end
   end

   assign out = out_reg;
   assign out_valid = out_valid_reg;
endmodule
`default_nettype wire

// ===== design/rtl_remote_limits.sv
// Purpose: Remote temperature reading, offset, limits, critical and alert
// Assumes: Converter results arrive synchronous to clk with a valid pulse
// Notes: Readings are 11-bit two's complement in eighths of a degree
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rtl_remote_limits
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Converter result, 11-bit signed in eighths of a degree
   input wire logic adc_valid,
   input wire logic [10:0] adc_data,
   // Alert and critical outputs
   output logic alert,
   output logic crit_active,
   output logic irq
);
   import rtl_pkg::*;

   // Register values
   logic [7:0] ofs_hi; // Offset integer byte
   logic [7:0] ofs_lo; // Offset fraction byte
   logic [7:0] hil_hi; // High setpoint integer byte
   logic [7:0] hil_lo; // High setpoint fraction byte
   logic [7:0] lol_hi; // Low setpoint integer byte
   logic [7:0] lol_lo; // Low setpoint fraction byte
   logic [7:0] crit_lim; // Critical limit, whole degrees
   logic [7:0] hyst; // Critical hysteresis, whole degrees
   logic [7:0] filt_cfg; // Filter field and alert mode bit
   logic [7:0] mask_q; // Alert mask, status layout
   logic [7:0] rdata_reg;
   logic [7:0] frac_snap_reg;
   logic [ST_W-1:0] status_reg;
   logic [ST_W-1:0] cond;
   logic [ST_W-1:0] clr_ok;
   logic signed [10:0] reading_reg;
   logic signed [10:0] sum, filt_out;
   logic filt_valid;
   logic sum_valid_reg;
   logic signed [10:0] sum_reg;
   logic crit_reg;
   logic alert_reg;
   logic stat_rd;

   // Write strobe decode, used by every writable register
   function automatic logic wr_hit(input logic we, input logic [7:0] addr,
                                   input logic [7:0] a);
      return we && (addr == a);
   endfunction

   // Join integer and fraction bytes into an 11-bit signed value
   function automatic logic signed [10:0] join_val(input logic [7:0] hi,
                                                   input logic [7:0] lo);
      return {hi, lo[7:8-FRAC_W]};
   endfunction

   // Per-register write strobes
   logic wr_ofs_hi;
   logic wr_ofs_lo;
   logic wr_hil_hi;
   logic wr_hil_lo;
   logic wr_lol_hi;
   logic wr_lol_lo;
   logic wr_crit;
   logic wr_hyst;
   logic wr_filt;
   logic wr_mask;

   // Bus signals passed in, so each decode follows strobe and address;
   // a decode reading them only inside the function could go stale
   assign wr_ofs_hi = wr_hit(reg_wr, reg_addr, ADDR_OFS_HI);
   assign wr_ofs_lo = wr_hit(reg_wr, reg_addr, ADDR_OFS_LO);
   assign wr_hil_hi = wr_hit(reg_wr, reg_addr, ADDR_HILIM_HI);
   assign wr_hil_lo = wr_hit(reg_wr, reg_addr, ADDR_HILIM_LO);
   assign wr_lol_hi = wr_hit(reg_wr, reg_addr, ADDR_LOLIM_HI);
   assign wr_lol_lo = wr_hit(reg_wr, reg_addr, ADDR_LOLIM_LO);
   assign wr_crit = wr_hit(reg_wr, reg_addr, ADDR_CRIT);
   assign wr_hyst = wr_hit(reg_wr, reg_addr, ADDR_HYST);
   assign wr_filt = wr_hit(reg_wr, reg_addr, ADDR_FILT);
   assign wr_mask = wr_hit(reg_wr, reg_addr, ADDR_MASK);

   // Software registers with their reset values
   // Offset integer byte
   rtl_reg8 #(.RST(RST_ZERO), .WMASK(8'hff)) u_ofs_hi
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_ofs_hi),
      .wdata(reg_wdata),
      .q(ofs_hi)
   );
   // Offset fraction byte, low bits forced to zero
   rtl_reg8 #(.RST(RST_ZERO), .WMASK(FRAC_MASK)) u_ofs_lo
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_ofs_lo),
      .wdata(reg_wdata),
      .q(ofs_lo)
   );
   // High setpoint integer byte
   rtl_reg8 #(.RST(RST_HILIM_HI), .WMASK(8'hff)) u_hil_hi
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_hil_hi),
      .wdata(reg_wdata),
      .q(hil_hi)
   );
   // High setpoint fraction byte
   rtl_reg8 #(.RST(RST_ZERO), .WMASK(FRAC_MASK)) u_hil_lo
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_hil_lo),
      .wdata(reg_wdata),
      .q(hil_lo)
   );
   // Low setpoint integer byte
   rtl_reg8 #(.RST(RST_ZERO), .WMASK(8'hff)) u_lol_hi
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_lol_hi),
      .wdata(reg_wdata),
      .q(lol_hi)
   );
   // Low setpoint fraction byte
   rtl_reg8 #(.RST(RST_ZERO), .WMASK(FRAC_MASK)) u_lol_lo
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_lol_lo),
      .wdata(reg_wdata),
      .q(lol_lo)
   );
   // Critical limit, rewritable at any time
   rtl_reg8 #(.RST(RST_CRIT), .WMASK(8'hff)) u_crit
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_crit),
      .wdata(reg_wdata),
      .q(crit_lim)
   );
   // Critical hysteresis
   rtl_reg8 #(.RST(RST_HYST), .WMASK(8'hff)) u_hyst
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_hyst),
      .wdata(reg_wdata),
      .q(hyst)
   );
   // Unused bits are dropped so a careless host cannot set them
   rtl_reg8 #(.RST(RST_ZERO), .WMASK(FILT_WMASK)) u_filt
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_filt),
      .wdata(reg_wdata),
      .q(filt_cfg)
   );
   // Alert mask, one bit per status flag
   rtl_reg8 #(.RST(RST_ZERO), .WMASK(8'h07)) u_mask
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_mask),
      .wdata(reg_wdata),
      .q(mask_q)
   );

   // Offset added to converter output; wraps like the eleven-bit format
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sum_reg <= '0;
         sum_valid_reg <= 1'b0;
      end
      else
      begin
         sum_valid_reg <= adc_valid;
         if (adc_valid)
            sum_reg <= adc_data + join_val(ofs_hi, ofs_lo);
      end
   end
   assign sum = sum_reg;

   // Filter selected by bits 2:1
   rtl_filter u_filter
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .mode(filt_cfg[FILT_LSB+1:FILT_LSB]),
      .sample_valid(sum_valid_reg),
      .sample(sum),
      .out_valid(filt_valid),
      .out(filt_out)
   );

   // Stored reading on the shifted scale, no correction applied here
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         reading_reg <= '0;
      else if (filt_valid)
         reading_reg <= filt_out;
   end

   // Limit comparisons, all signed on the same scale
   always_comb
   begin
      cond = '0;
      cond[ST_HIGH] = reading_reg > join_val(hil_hi, hil_lo);
      cond[ST_LOW] = reading_reg < join_val(lol_hi, lol_lo);
      cond[ST_CRIT] = crit_reg;
   end

   // Critical with hysteresis; limit minus hysteresis widened to avoid wrap
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         crit_reg <= 1'b0;
      else if (reading_reg > join_val(crit_lim, RST_ZERO))
         crit_reg <= 1'b1;
      else if (13'(reading_reg) <
               13'(signed'({crit_lim, 3'b000}))
               - signed'(13'({hyst, 3'b000})))
         crit_reg <= 1'b0;
   end

   assign stat_rd = reg_rd && (reg_addr == ADDR_STAT);
   // A flag may clear on read only when its condition is already gone
   assign clr_ok = stat_rd ? ~cond : '0;

   // Sticky status: a live condition always wins over the read clear
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         status_reg <= '0;
      else
         status_reg <= cond | (status_reg & ~clr_ok);
   end

   // Fraction captured with the integer byte read
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         frac_snap_reg <= '0;
      else if (reg_rd && reg_addr == ADDR_READ_HI)
         frac_snap_reg <= {reading_reg[2:0], 5'b00000};
   end

   // Read data one cycle after the strobe; unmapped reads as zero
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdata_reg <= '0;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            ADDR_READ_HI: rdata_reg <= reading_reg[10:3];
            ADDR_READ_LO: rdata_reg <= frac_snap_reg;
            ADDR_OFS_HI: rdata_reg <= ofs_hi;
            ADDR_OFS_LO: rdata_reg <= ofs_lo;
            ADDR_HILIM_HI: rdata_reg <= hil_hi;
            ADDR_HILIM_LO: rdata_reg <= hil_lo;
            ADDR_LOLIM_HI: rdata_reg <= lol_hi;
            ADDR_LOLIM_LO: rdata_reg <= lol_lo;
            ADDR_CRIT: rdata_reg <= crit_lim;
            ADDR_HYST: rdata_reg <= hyst;
            ADDR_FILT: rdata_reg <= filt_cfg;
            ADDR_STAT: rdata_reg <= {5'b00000, status_reg};
            ADDR_MASK: rdata_reg <= mask_q;
            default: rdata_reg <= '0;
         endcase
      end
      else
         rdata_reg <= '0;
   end
   assign reg_rdata = rdata_reg;

   // Alert: comparator follows conditions, interrupt mode follows flags
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         alert_reg <= 1'b0;
      else if (filt_cfg[MODE_BIT])
         alert_reg <= |(cond & ~mask_q[ST_W-1:0]);
      else
         alert_reg <= |(status_reg & ~mask_q[ST_W-1:0]);
   end

   assign alert = alert_reg;
   assign crit_active = crit_reg;
   // Level interrupt from unmasked sticky flags
   assign irq = |(status_reg & ~mask_q[ST_W-1:0]);
endmodule
`default_nettype wire

// ===== testbench/rtl_adc_model.sv
// Purpose: Converter model, one result per go pulse
// Assumes: go is a one-cycle pulse
// Notes: Data is inverted outside valid so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module rtl_adc_model
(
   // Clock
   input wire logic clk,
   // Request
   input wire logic go,
   input wire logic [10:0] value,
   // Result
   output logic adc_valid,
   output logic [10:0] adc_data
);
   initial adc_valid = 1'b0;
   initial adc_data = 11'h000;
   // Pulse valid, scramble data after it
   always @(posedge clk)
   begin
      adc_valid <= go;
      adc_data <= go ? value : ~adc_data;
   end
endmodule
`default_nettype wire

// ===== testbench/rtl_limits_sva.sv
// Purpose: Port checker for the remote limit block
// Assumes: One clock, synchronous reset
// Notes: Alarm state is inferred from port timing only
`timescale 1ns/1ps
`default_nettype none
module rtl_limits_sva
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Converter and outputs
   input wire logic adc_valid,
   input wire logic crit_active,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Read data stands only in its slot
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata");
   // Unused low bits of fraction bytes and filter config bits 7:3 read zero
   property p_frac_zero;
      reg_rd && reg_addr == 8'h10 |=> reg_rdata[4:0] == 5'h00;
   endproperty
   a_frac_zero: assert property (p_frac_zero) else $error("frac");
   property p_ofs_zero;
      reg_rd && reg_addr == 8'h12 |=> reg_rdata[4:0] == 5'h00;
   endproperty
   a_ofs_zero: assert property (p_ofs_zero) else $error("ofs");
   property p_hi_zero;
      reg_rd && reg_addr == 8'h13 |=> reg_rdata[4:0] == 5'h00;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("hilim");
   property p_lo_zero;
      reg_rd && reg_addr == 8'h14 |=> reg_rdata[4:0] == 5'h00;
   endproperty
   a_lo_zero: assert property (p_lo_zero) else $error("lolim");
   property p_cfg_rsv;
      reg_rd && reg_addr == 8'hbf |=> reg_rdata[7:3] == 5'h00;
   endproperty
   a_cfg_rsv: assert property (p_cfg_rsv) else $error("cfg");
   // Sticky flags drop only after a host access
   property p_irq_hold;
      $fell(irq) |-> $past(reg_rd) || $past(reg_wr) || $past(reg_rd, 2);
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq");
   // Critical releases only after a new reading or a limit write
   property p_crit_hold;
      $fell(crit_active) |-> $past(adc_valid, 4) || $past(adc_valid, 5)
         || $past(reg_wr, 2) || $past(reg_wr, 3);
   endproperty
   a_crit_hold: assert property (p_crit_hold) else $error("crit");
endmodule
bind rtl_remote_limits rtl_limits_sva u_sva (.clk(clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .adc_valid(adc_valid),
   .crit_active(crit_active), .irq(irq));
`default_nettype wire

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the remote limit block
// Assumes: Read data one cycle after the strobe
// Notes: Conversion waits cover the five-cycle alert path
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic go = 1'b0;
   logic [10:0] value = 11'h000;
   logic adc_valid;
   logic [10:0] adc_data;
   logic alert;
   logic crit_active;
   logic irq;
   int num_errors = 0;
   int n_checks = 0;
   logic [7:0] ra [9] = '{8'h07, 8'h08, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19,
      8'h21, 8'hbf};
   logic [7:0] rv [9] = '{8'h46, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55,
      8'h0a, 8'h00};
   // Host keeps configuration bits 7:3 at zero
   logic [7:0] wv [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h64,
      8'hff, 8'h07};
   logic [7:0] xv [9] = '{8'hff, 8'hff, 8'hff, 8'he0, 8'he0, 8'he0, 8'h64,
      8'hff, 8'h07};
   always #4 clk = ~clk;
   rtl_remote_limits u_rtl_remote_limits (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_valid(adc_valid),
      .adc_data(adc_data), .alert(alert), .crit_active(crit_active),
      .irq(irq));
   rtl_adc_model u_rtl_adc_model (.clk(clk), .go(go), .value(value),
      .adc_valid(adc_valid), .adc_data(adc_data));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Sample just after the edge that makes the read data stand
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   task automatic conv(input logic [10:0] v);
      @(posedge clk);
      go <= 1'b1;
      value <= v;
      @(posedge clk);
      go <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic conclude;
      if (num_errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Watchdog against a hung sequence
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      conclude();
   end
   initial
   begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      // Reset values, masked writes, restore
      for (int i = 0; i < 9; i++)
         rdc(ra[i], rv[i]);
      for (int i = 0; i < 9; i++)
      begin
         wr(ra[i], wv[i]);
         rdc(ra[i], xv[i]);
      end
      for (int i = 0; i < 9; i++)
         wr(ra[i], rv[i]);
      wr(8'h02, 8'hff);
      rdc(8'h02, 8'h00);
      // Offset sum; fraction snapshot outlives a new conversion
      wr(8'h11, 8'h02);
      wr(8'h12, 8'h20);
      conv(11'h0a4);
      rdc(8'h01, 8'h16);
      conv(11'h000);
      rdc(8'h10, 8'ha0);
      rdc(8'h01, 8'h02);
      wr(8'h11, 8'h00);
      wr(8'h12, 8'h00);
      conv(11'h7e6);
      rdc(8'h01, 8'hfc);
      rdc(8'h10, 8'hc0);
      // Both minimal codes halve the step, maximum takes an eighth
      conv(11'h0a0);
      wr(8'hbf, 8'h02);
      conv(11'h140);
      rdc(8'h01, 8'h1e);
      wr(8'hbf, 8'h04);
      conv(11'h140);
      rdc(8'h01, 8'h23);
      wr(8'hbf, 8'h06);
      conv(11'h140);
      rdc(8'h01, 8'h23);
      rdc(8'h10, 8'ha0);
      wr(8'hbf, 8'h00);
      // High alarm latches past its condition
      conv(11'h0a0);
      rdc(8'hf0, 8'h03);
      rdc(8'hf0, 8'h00);
      wr(8'h07, 8'h30);
      conv(11'h190);
      chk({7'h00, irq}, 8'h01);
      conv(11'h0a0);
      chk({7'h00, alert}, 8'h01);
      rdc(8'hf0, 8'h01);
      rdc(8'hf0, 8'h00);
      chk({7'h00, alert}, 8'h00);
      // Masked low alarm still sets its flag
      wr(8'hf1, 8'h02);
      wr(8'h08, 8'h10);
      conv(11'h050);
      chk({7'h00, irq}, 8'h00);
      rdc(8'hf0, 8'h02);
      wr(8'h08, 8'h00);
      wr(8'hf1, 8'h00);
      conv(11'h0a0);
      rdc(8'hf0, 8'h02);
      // Critical with hysteresis band of ten degrees
      conv(11'h2d0);
      chk({7'h00, crit_active}, 8'h01);
      conv(11'h280);
      chk({7'h00, crit_active}, 8'h01);
      conv(11'h257);
      chk({7'h00, crit_active}, 8'h00);
      // Comparator mode follows the condition
      wr(8'hbf, 8'h01);
      conv(11'h190);
      chk({7'h00, alert}, 8'h01);
      conv(11'h0a0);
      chk({7'h00, alert}, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
